/* File: shared/ddms_pkg.sv */
// Constants for the DDR2 mode-register decode block.
// Assumes command pins arrive asynchronous to the device clock and are synchronised in the decode block.
package ddms_pkg;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned BANK_W = 3;
  // Bank select codes for the four registers
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_EXT1 = 2'h1;
  localparam logic [1:0] SEL_EXT2 = 2'h2;
  localparam logic [1:0] SEL_EXT3 = 2'h3;
  // Main register fields
  localparam int unsigned MR_BL_LSB = 0;
  localparam int unsigned MR_BT_BIT = 3;
  localparam int unsigned MR_CL_LSB = 4;
  localparam int unsigned MR_TM_BIT = 7;
  localparam int unsigned MR_DLLRST_BIT = 8;
  localparam int unsigned MR_WR_LSB = 9;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  // Extended register 1 fields
  localparam int unsigned E1_DLL_DIS_BIT = 0;
  localparam int unsigned E1_HALF_BIT = 1;
  localparam int unsigned E1_RTT0_BIT = 2;
  localparam int unsigned E1_AL_LSB = 3;
  localparam int unsigned E1_RTT1_BIT = 6;
  localparam int unsigned E1_CAL_LSB = 7;
  localparam int unsigned E1_STB_N_DIS_BIT = 10;
  localparam int unsigned E1_RSTB_EN_BIT = 11;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DRIVE_HI = 3'h1;
  localparam logic [2:0] CAL_DRIVE_LO = 3'h2;
  localparam logic [2:0] CAL_ADJUST = 3'h4;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  // Extended register 2 fields
  localparam int unsigned E2_DCC_BIT = 3;
  localparam int unsigned E2_HTSR_BIT = 7;
  localparam int unsigned E2_PARTIAL_ARRAY_SELF_REFRESH_LSB = 0;
  localparam logic [ADDR_W-1:0] REG_RST = 14'h0000;
  // Calibration mode as seen by the output stage
  typedef enum logic [2:0] {
    CM_OFF = 3'b000,
    CM_DRIVE_HI = 3'b001,
    CM_DRIVE_LO = 3'b010,
    CM_ADJUST = 3'b100,
    CM_DEFAULT = 3'b111
  } ddms_cal_t;
endpackage

/* File: design/ddms_mode_regs.sv */
// Mode-register decode and storage for a DDR2 device core.
// Assumes command pins arrive from pads asynchronous to i_mclk and are synchronised here.
module ddms_mode_regs (
  input wire logic i_mclk, // Device clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_ce, // Clock enable for all state
  input wire logic i_cke, // Memory clock-enable pin
  input wire logic i_cs_n, // Chip select pin
  input wire logic i_ras_n, // Row strobe pin
  input wire logic i_cas_n, // Column strobe pin
  input wire logic i_we_n, // Write enable pin
  input wire logic [ddms_pkg::BANK_W-1:0] i_bank_select, // Bank select pins
  input wire logic [ddms_pkg::ADDR_W-1:0] i_addr, // Address pins
  input wire logic i_self_refresh, // Core is in self refresh
  input wire logic i_read_active, // Core is driving read data
  output logic [ddms_pkg::ADDR_W-1:0] o_main_mode_reg, // Main register
  output logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_one, // Extended one
  output logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_two, // Extended two
  output logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_three, // Extended three
  output logic [3:0] o_written, // Per register: written since reset
  output logic o_write_pulse, // One cycle after any register write
  output logic o_burst_eight, // Burst length eight selected
  output logic o_burst_interleave, // Interleaved order
  output logic [2:0] o_cas_latency, // Read latency field
  output logic [2:0] o_write_recovery, // Write recovery field
  output logic o_loop_reset, // Loop reset requested by last main write
  output logic o_loop_enable, // Delay-locked loop running
  output logic o_half_drive, // Half strength driver
  output logic [2:0] o_additive_latency, // Added latency field
  output logic [1:0] o_on_die_termination_control, // Termination select {b6,b2}
  output logic [2:0] o_driver_calibration, // Calibration mode
  output logic o_strobe_n_oe, // Complementary strobe enabled
  output logic o_read_strobe_oe, // Read strobe driven now
  output logic o_read_strobe_n_oe, // Complementary read strobe driven now
  output logic o_data_mask_en, // Data mask input honoured
  output logic o_fast_self_refresh, // High temperature refresh rate
  output logic [2:0] o_partial_array_self_refresh, // Refresh array subset
  output logic o_duty_cycle_corrector // Duty cycle corrector control
);
  // ==========================================================
  // Pin synchronisers
  // Pins cross into i_mclk through two flops; the first stage feeds only the second.
  localparam int unsigned PIN_W = 1 + 4 + ddms_pkg::BANK_W + ddms_pkg::ADDR_W;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic sr_meta_ff;
  logic sr_ff;
  assign pin_raw = {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_select, i_addr};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sr_meta_ff <= 1'b0;
      sr_ff <= 1'b0;
    end else if (i_ce) begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sr_meta_ff <= i_self_refresh;
      sr_ff <= sr_meta_ff;
    end
  end

  // ==========================================================
  // Command decode
  wire [ddms_pkg::ADDR_W-1:0] s_addr = sync2_ff[ddms_pkg::ADDR_W-1:0];
  wire [ddms_pkg::BANK_W-1:0] s_bank = sync2_ff[ddms_pkg::ADDR_W +: ddms_pkg::BANK_W];
  wire [3:0] s_cmd_n = sync2_ff[ddms_pkg::ADDR_W + ddms_pkg::BANK_W +: 4];
  wire s_cke = sync2_ff[PIN_W-1];
  // Clock enable must be high; precharge state is the controller's duty
  wire mode_write_command = s_cke && (s_cmd_n == 4'h0);
  wire [1:0] sel = s_bank[1:0];
  wire [3:0] hit;

  // ==========================================================
  // Register storage
  // Reset value is zero even though contents are formally undefined until written.
  logic [ddms_pkg::ADDR_W-1:0] regs_ff [4];
  logic [3:0] written_ff;
  logic write_pulse_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_reg
      assign hit[gi] = mode_write_command && (sel == 2'(gi));
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          regs_ff[gi] <= ddms_pkg::REG_RST;
          written_ff[gi] <= 1'b0;
        end else if (i_ce && hit[gi]) begin
          regs_ff[gi] <= s_addr;
          written_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      write_pulse_ff <= 1'b0;
    end else if (i_ce) begin
      write_pulse_ff <= mode_write_command;
    end
  end

  // ==========================================================
  // Field decode
  wire [ddms_pkg::ADDR_W-1:0] mr = regs_ff[ddms_pkg::SEL_MAIN];
  wire [ddms_pkg::ADDR_W-1:0] e1 = regs_ff[ddms_pkg::SEL_EXT1];
  wire [ddms_pkg::ADDR_W-1:0] e2 = regs_ff[ddms_pkg::SEL_EXT2];
  wire [2:0] bl_code = mr[ddms_pkg::MR_BL_LSB +: 3];
  wire nxt_burst_eight = (bl_code == ddms_pkg::BL_EIGHT);
  wire nxt_interleave = mr[ddms_pkg::MR_BT_BIT];
  wire [2:0] nxt_cl = mr[ddms_pkg::MR_CL_LSB +: 3];
  wire [2:0] nxt_wr = mr[ddms_pkg::MR_WR_LSB +: 3];
  wire nxt_loop_reset = mr[ddms_pkg::MR_DLLRST_BIT];
  // Loop drops in self refresh without touching the stored bit
  wire nxt_loop_en = !e1[ddms_pkg::E1_DLL_DIS_BIT] && !sr_ff;
  wire nxt_half = e1[ddms_pkg::E1_HALF_BIT];
  wire [2:0] nxt_al = e1[ddms_pkg::E1_AL_LSB +: 3];
  wire [1:0] nxt_odt = {e1[ddms_pkg::E1_RTT1_BIT], e1[ddms_pkg::E1_RTT0_BIT]};
  wire [2:0] cal_raw = e1[ddms_pkg::E1_CAL_LSB +: 3];
  wire strobe_n_en = !e1[ddms_pkg::E1_STB_N_DIS_BIT];
  wire rstb_en = e1[ddms_pkg::E1_RSTB_EN_BIT];
  wire nxt_rstb_oe = rstb_en && i_read_active;
  wire nxt_rstb_n_oe = nxt_rstb_oe && strobe_n_en;
  wire nxt_mask_en = !rstb_en;
  wire nxt_fast_sr = e2[ddms_pkg::E2_HTSR_BIT];
  ddms_pkg::ddms_cal_t nxt_cal;

  // Unlisted codes are reserved; treat as calibration off
  always_comb begin
    case (cal_raw)
      ddms_pkg::CAL_EXIT: nxt_cal = ddms_pkg::CM_OFF;
      ddms_pkg::CAL_DRIVE_HI: nxt_cal = ddms_pkg::CM_DRIVE_HI;
      ddms_pkg::CAL_DRIVE_LO: nxt_cal = ddms_pkg::CM_DRIVE_LO;
      ddms_pkg::CAL_ADJUST: nxt_cal = ddms_pkg::CM_ADJUST;
      ddms_pkg::CAL_DEFAULT: nxt_cal = ddms_pkg::CM_DEFAULT;
      default: nxt_cal = ddms_pkg::CM_OFF;
    endcase
  end

  // ==========================================================
  // Output flops
  // One short flop process per output keeps each reset value beside its source
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_main_mode_reg <= ddms_pkg::REG_RST;
    end else if (i_ce) begin
      o_main_mode_reg <= mr;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_extended_mode_reg_one <= ddms_pkg::REG_RST;
    end else if (i_ce) begin
      o_extended_mode_reg_one <= e1;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_extended_mode_reg_two <= ddms_pkg::REG_RST;
    end else if (i_ce) begin
      o_extended_mode_reg_two <= e2;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_extended_mode_reg_three <= ddms_pkg::REG_RST;
    end else if (i_ce) begin
      o_extended_mode_reg_three <= regs_ff[ddms_pkg::SEL_EXT3];
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_written <= 4'h0;
    end else if (i_ce) begin
      o_written <= written_ff;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_write_pulse <= 1'b0;
    end else if (i_ce) begin
      o_write_pulse <= write_pulse_ff;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_burst_eight <= 1'b0;
    end else if (i_ce) begin
      o_burst_eight <= nxt_burst_eight;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_burst_interleave <= 1'b0;
    end else if (i_ce) begin
      o_burst_interleave <= nxt_interleave;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cas_latency <= 3'h0;
    end else if (i_ce) begin
      o_cas_latency <= nxt_cl;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_write_recovery <= 3'h0;
    end else if (i_ce) begin
      o_write_recovery <= nxt_wr;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_loop_reset <= 1'b0;
    end else if (i_ce) begin
      o_loop_reset <= nxt_loop_reset;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_loop_enable <= 1'b0;
    end else if (i_ce) begin
      o_loop_enable <= nxt_loop_en;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_half_drive <= 1'b0;
    end else if (i_ce) begin
      o_half_drive <= nxt_half;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_additive_latency <= 3'h0;
    end else if (i_ce) begin
      o_additive_latency <= nxt_al;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_on_die_termination_control <= 2'h0;
    end else if (i_ce) begin
      o_on_die_termination_control <= nxt_odt;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_driver_calibration <= 3'h0;
    end else if (i_ce) begin
      o_driver_calibration <= nxt_cal;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_strobe_n_oe <= 1'b0;
    end else if (i_ce) begin
      o_strobe_n_oe <= strobe_n_en;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_read_strobe_oe <= 1'b0;
    end else if (i_ce) begin
      o_read_strobe_oe <= nxt_rstb_oe;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_read_strobe_n_oe <= 1'b0;
    end else if (i_ce) begin
      o_read_strobe_n_oe <= nxt_rstb_n_oe;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_data_mask_en <= 1'b1;
    end else if (i_ce) begin
      o_data_mask_en <= nxt_mask_en;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fast_self_refresh <= 1'b0;
    end else if (i_ce) begin
      o_fast_self_refresh <= nxt_fast_sr;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_partial_array_self_refresh <= 3'h0;
    end else if (i_ce) begin
      o_partial_array_self_refresh <= e2[ddms_pkg::E2_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 3];
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_duty_cycle_corrector <= 1'b0;
    end else if (i_ce) begin
      o_duty_cycle_corrector <= e2[ddms_pkg::E2_DCC_BIT];
    end
  end
endmodule

/* File: bench/ddms_mode_regs_checker.sv */
// Timing checks on the mode-register block ports.
// Assumes i_ce stays high while writes travel through the block.
module ddms_mode_regs_checker (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_ce, // Run enable
  input wire logic i_cke, // Clock enable pin
  input wire logic i_cs_n, // Select
  input wire logic i_ras_n, // Row strobe
  input wire logic i_cas_n, // Column strobe
  input wire logic i_we_n, // Write enable
  input wire logic [ddms_pkg::BANK_W-1:0] i_bank_select, // Bank pins
  input wire logic [ddms_pkg::ADDR_W-1:0] i_addr, // Address pins
  input wire logic i_self_refresh, // Self refresh
  input wire logic [ddms_pkg::ADDR_W-1:0] o_main_mode_reg, // Main
  input wire logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_one, // Ext one
  input wire logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_two, // Ext two
  input wire logic [ddms_pkg::ADDR_W-1:0] o_extended_mode_reg_three, // Ext three
  input wire logic o_write_pulse, // Write seen
  input wire logic o_burst_eight, // Burst eight
  input wire logic o_burst_interleave, // Order
  input wire logic o_loop_enable, // Loop on
  input wire logic o_data_mask_en, // Mask on
  input wire logic [2:0] o_driver_calibration // Cal mode
);
  // ====================
  // Decode
  wire wr_any = i_ce && i_cke && !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
  wire [1:0] sel = i_bank_select[1:0];
  wire [2:0] cal = o_extended_mode_reg_one[9:7];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ====================
  // Assertions
  a_pulse_after_write: assert property (wr_any |-> ##4 o_write_pulse)
    else $error("write pulse missing");
  a_no_stray_pulse: assert property (o_write_pulse |-> $past(wr_any, 4))
    else $error("pulse without write");
  a_main_load: assert property (wr_any && sel == ddms_pkg::SEL_MAIN
    |-> ##4 o_main_mode_reg == $past(i_addr, 4)) else $error("main value wrong");
  a_ext_one_load: assert property (wr_any && sel == ddms_pkg::SEL_EXT1
    |-> ##4 o_extended_mode_reg_one == $past(i_addr, 4)) else $error("ext one wrong");
  a_ext_two_load: assert property (wr_any && sel == ddms_pkg::SEL_EXT2
    |-> ##4 o_extended_mode_reg_two == $past(i_addr, 4)) else $error("ext two wrong");
  a_ext_three_load: assert property (wr_any && sel == ddms_pkg::SEL_EXT3
    |-> ##4 o_extended_mode_reg_three == $past(i_addr, 4)) else $error("ext three wrong");
  a_main_holds: assert property (!$past(wr_any && sel == ddms_pkg::SEL_MAIN, 4)
    |-> $stable(o_main_mode_reg)) else $error("main changed unasked");
  a_burst_decode: assert property (o_burst_interleave == o_main_mode_reg[3] &&
    o_burst_eight == (o_main_mode_reg[2:0] == ddms_pkg::BL_EIGHT)) else $error("burst bad");
  a_cal_decode: assert property (o_driver_calibration ==
    ((cal inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7}) ? cal : 3'h0)) else $error("cal bad");
  a_mask_vs_strobe: assert property (o_data_mask_en == !o_extended_mode_reg_one[11])
    else $error("mask wrong");
  a_loop_off_refresh: assert property (i_self_refresh [*5] |-> !o_loop_enable)
    else $error("loop on in self refresh");
endmodule

bind ddms_mode_regs ddms_mode_regs_checker chk_u (.i_mclk, .i_rst, .i_ce, .i_cke, .i_cs_n,
  .i_ras_n, .i_cas_n, .i_we_n, .i_bank_select, .i_addr, .i_self_refresh, .o_main_mode_reg,
  .o_extended_mode_reg_one, .o_extended_mode_reg_two, .o_extended_mode_reg_three,
  .o_write_pulse, .o_burst_eight, .o_burst_interleave, .o_loop_enable, .o_data_mask_en,
  .o_driver_calibration);

/* File: bench/ddms_ctrl_model.sv */
// Memory controller model driving the command and address pins.
// Assumes callers keep banks precharged; it sends one command per call.
module ddms_ctrl_model (
  input wire logic i_mclk, // Clock
  output logic o_cke, // Clock enable pin
  output logic o_cs_n, // Select
  output logic o_ras_n, // Row strobe
  output logic o_cas_n, // Column strobe
  output logic o_we_n, // Write enable
  output logic [ddms_pkg::BANK_W-1:0] o_bank_select, // Bank pins
  output logic [ddms_pkg::ADDR_W-1:0] o_addr // Address pins
);
  initial begin
    o_cke = 1'h1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_bank_select = 3'h0;
    o_addr = 14'h0000;
  end
  // ====================
  // One write per call; a low cke is only for refusal cases
  task automatic write_reg(input logic [1:0] sel, input logic [13:0] val, input logic cke);
    @(negedge i_mclk);
    o_cke = cke;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h0;
    o_bank_select = {1'h0, sel};
    o_addr = val;
    @(negedge i_mclk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_cke = 1'h1;
    // Released pins show no stale copy
    o_addr = ~val;
    o_bank_select = ~o_bank_select;
  endtask
endmodule

/* File: bench/test_ddms_mode_regs.sv */
// Self-checking bench for the mode-register block.
// Assumes the controller model drives pins on falling edges only.
module test_ddms_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] sel; logic [13:0] val;} ddms_row_t;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_self_refresh = 1'h0, i_read_active = 1'h0;
  logic i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
  logic [2:0] i_bank_select, o_cas_latency, o_write_recovery, o_additive_latency;
  logic [2:0] o_driver_calibration;
  logic [13:0] i_addr;
  logic [13:0] regs [4];
  logic [3:0] o_written;
  logic o_write_pulse, o_burst_eight, o_burst_interleave, o_loop_reset, o_loop_enable;
  logic o_half_drive, o_read_strobe_oe, o_data_mask_en, o_fast_self_refresh;
  int miscompares = 0, samples_checked = 0;
  ddms_row_t rows [7] = '{'{2'h2, 14'h0080}, '{2'h3, 14'h0000}, '{2'h1, 14'h0000},
    '{2'h0, 14'h0100}, '{2'h1, 14'h0b90}, '{2'h1, 14'h0812}, '{2'h0, 14'h0a3b}};
  logic [2:0] cal_in [6] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0, 3'h3};
  logic [2:0] cal_exp [6] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0, 3'h0};
  always #2.5 i_mclk = ~i_mclk;
  ddms_ctrl_model ctl_u (.i_mclk, .o_cke(i_cke), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
    .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_bank_select(i_bank_select), .o_addr(i_addr));
  ddms_mode_regs dut_u (.i_mclk, .i_rst, .i_ce, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
    .i_bank_select, .i_addr, .i_self_refresh, .i_read_active, .o_main_mode_reg(regs[0]),
    .o_extended_mode_reg_one(regs[1]), .o_extended_mode_reg_two(regs[2]),
    .o_extended_mode_reg_three(regs[3]), .o_written, .o_write_pulse, .o_burst_eight,
    .o_burst_interleave, .o_cas_latency, .o_write_recovery, .o_loop_reset, .o_loop_enable,
    .o_half_drive, .o_additive_latency, .o_on_die_termination_control(),
    .o_driver_calibration, .o_strobe_n_oe(), .o_read_strobe_oe, .o_read_strobe_n_oe(),
    .o_data_mask_en, .o_fast_self_refresh, .o_partial_array_self_refresh(),
    .o_duty_cycle_corrector());
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Outputs move three edges after the sampling edge; look while the pulse stands
  task automatic wr(input logic [1:0] sel, input logic [13:0] val, input logic cke);
    ctl_u.write_reg(sel, val, cke);
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_mclk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst = 1'h0;
    foreach (rows[k]) begin
      wr(rows[k].sel, rows[k].val, 1'h1);
      chk("pulse", o_write_pulse, 14'h1);
      chk("reg", regs[rows[k].sel], rows[k].val);
    end
    chk("burst8", o_burst_eight, 14'h1);
    chk("order", o_burst_interleave, 14'h1);
    chk("cas", o_cas_latency, 14'h3);
    chk("wrec", o_write_recovery, 14'h5);
    chk("lreset", o_loop_reset, 14'h0);
    chk("half", o_half_drive, 14'h1);
    chk("loop", o_loop_enable, 14'h1);
    chk("addlat", o_additive_latency, 14'h2);
    chk("mask", o_data_mask_en, 14'h0);
    chk("hotref", o_fast_self_refresh, 14'h1);
    i_read_active = 1'h1;
    repeat (2) @(negedge i_mclk);
    chk("rstrobe", o_read_strobe_oe, 14'h1);
    i_read_active = 1'h0;
    foreach (cal_in[k]) begin
      wr(2'h1, {4'h0, cal_in[k], 7'h12}, 1'h1);
      chk("cal", o_driver_calibration, {11'h0, cal_exp[k]});
    end
    wr(2'h0, 14'h1555, 1'h0);
    chk("refused", o_write_pulse, 14'h0);
    chk("kept", regs[0], 14'h0a3b);
    i_self_refresh = 1'h1;
    repeat (6) @(negedge i_mclk);
    chk("srloop", o_loop_enable, 14'h0);
    i_self_refresh = 1'h0;
    repeat (6) @(negedge i_mclk);
    chk("srexit", o_loop_enable, 14'h1);
    i_rst = 1'h1;
    @(negedge i_mclk);
    chk("rstmain", regs[0], 14'h0000);
    chk("rstwr", o_written, 14'h0);
    chk("rstmask", o_data_mask_en, 14'h1);
    i_rst = 1'h0;
    wr(2'h3, 14'h0000, 1'h1);
    chk("rewrite", o_written, 14'h8);
    stop_test();
  end
endmodule
